/* File: include/stc_pkg.sv */
// Package for the self-test control block: register map, fields, types
package stc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [11:0] STC_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STC_STAT_OFFSET = 12'h004;

    // Field positions of the control register
    localparam int STC_TXO_BIT = 18;
    localparam int STC_TEST_COUNTER_CLEAR_BIT = 17;
    localparam int STC_LOOP_BIT = 16;
    localparam int STC_LLC_LSB = 8;
    localparam int STC_RPD_BIT = 10;
    localparam int STC_DESC_BIT = 9;
    localparam int STC_SCR_BIT = 8;
    localparam int STC_ERR_BIT = 6;
    localparam int STC_FLIP_BIT = 5;
    localparam int STC_PV_BIT = 4;
    localparam int STC_PAT_LSB = 0;

    // Reset values
    localparam logic [2:0] STC_LLC_RESET = 3'h7;
    localparam logic [3:0] STC_PAT_RESET = 4'h0;

    // Pattern selection codes
    localparam logic [3:0] STC_PAT_SIMULTANEOUS_SWITCHING_PATTERN = 4'h0;
    localparam logic [3:0] STC_PAT_HTDP = 4'h1;
    localparam logic [3:0] STC_PAT_LTDP = 4'h2;
    localparam logic [3:0] STC_PAT_LFSC = 4'h3;
    localparam logic [3:0] STC_PAT_COMP = 4'h4;
    localparam logic [3:0] STC_PAT_LONE = 4'h5;
    localparam logic [3:0] STC_PAT_MFTP = 4'h6;
    localparam logic [3:0] STC_PAT_HFTP = 4'h7;
    localparam logic [3:0] STC_PAT_LFTP = 4'h8;

    // Received pattern definition that asks for scrambled transmit
    localparam logic [7:0] STC_PD_SCRAMBLED = 8'h80;

    // AXI responses
    localparam logic [1:0] STC_RESP_OKAY = 2'h0;
    localparam logic [1:0] STC_RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Link layer function enables driven to the port
    typedef struct packed {
        logic scrambler_en;
        logic descrambler_en;
        logic primitive_drop_en;
    } stc_llc_en_t;

    // Physical layer test controls driven to the port
    typedef struct packed {
        logic transmit_only_active;
        logic near_loopback_active;
        logic test_activate_allow;
        logic [3:0] pattern_sel;
        logic pattern_valid;
        logic pattern_long;
        logic flip_disparity;
        logic outside_frame_error_allow;
    } stc_phy_ctl_t;

    // Complete block state
    typedef struct packed {
        logic transmit_only_request;
        logic near_analog_loopback_request;
        logic [2:0] link_layer_control;
        logic [2:0] llc_applied;
        logic outside_frame_error_allow;
        logic flip;
        logic pattern_long;
        logic [3:0] pattern_sel;
        logic counter_clear_pulse;
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } stc_state_t;

endpackage

/* File: hdl/stc_control.sv */
// Self-test control register and link/physical layer test steering
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RL1: Setting transmit-only while no drive is connected starts output of the selected non-compliant pattern.
// RL2: Writing one to counter-clear zeroes the frame count, error status and dword error count registers.
// RL3: Loopback request at one puts the physical layer in near-end analog loopback with the configured pattern.
// RL4: During near-end analog loopback no test-activate frame is sent to the drive.
// RL5: Software should request loopback only in partial or slumber, or with the drive gone and no communication.
// RL6: In normal mode a new link layer control value reaches the link only while port reset detection is one.
// RL7: Bit 10 enables primitive drop in normal mode when one and in test mode when zero.
// RL8: Bit 9 enables the descrambler in normal mode when one and in test mode when zero.
// RL9: Bit 8 enables the scrambler in normal mode when one and in test mode when zero.
// RL10: Entering responder far-end transmit test with pattern definition 80h clears the scrambler bit.
// RL11: Error-allow at zero passes only in-frame errors to the serial error register, at one all errors.
// RL12: The pattern field selects nine patterns 0h to 8h, values 9h to Fh are reserved.
// RL13: Reserved bits read as zero and ignore writes.
module stc_control (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Port status, same clock domain
    input wire logic port_reset_detect,
    input wire logic test_mode,
    input wire logic drive_connected,
    input wire logic responder_tx_entry,
    input wire logic [7:0] received_pattern_definition,
    // Port controls
    output stc_pkg::stc_llc_en_t llc_en,
    output stc_pkg::stc_phy_ctl_t phy_ctl,
    output logic test_counter_clear
);

    stc_pkg::stc_state_t st_reg;
    stc_pkg::stc_state_t st_next;
    logic wr_fire;
    logic wr_ctrl;
    logic [31:0] wr_merged;
    logic [31:0] ctrl_view;
    logic [31:0] stat_view;
    logic scr_auto_clear;

    ////////////////////////////////////////////////////////////////////////
    // Handshakes
    assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_held && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    // Write complete once both halves are held
    assign wr_fire = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    assign wr_ctrl = wr_fire && (st_reg.aw_addr == stc_pkg::STC_CTRL_OFFSET);

    // Byte lane merge over the current control view
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_merged[i*8 +: 8] = st_reg.w_strb[i] ?
                st_reg.w_data[i*8 +: 8] : ctrl_view[i*8 +: 8];
        end
    end

    // Control register readback, reserved bits zero
    always_comb begin
        ctrl_view = 32'h0000_0000; // RL13
        ctrl_view[stc_pkg::STC_TXO_BIT] = st_reg.transmit_only_request;
        ctrl_view[stc_pkg::STC_LOOP_BIT] =
            st_reg.near_analog_loopback_request;
        ctrl_view[stc_pkg::STC_LLC_LSB +: 3] = st_reg.link_layer_control;
        ctrl_view[stc_pkg::STC_ERR_BIT] = st_reg.outside_frame_error_allow;
        ctrl_view[stc_pkg::STC_FLIP_BIT] = st_reg.flip;
        ctrl_view[stc_pkg::STC_PV_BIT] = st_reg.pattern_long;
        ctrl_view[stc_pkg::STC_PAT_LSB +: 4] = st_reg.pattern_sel;
    end

    // Status register: link settings in force and port state
    always_comb begin
        stat_view = 32'h0000_0000;
        stat_view[2:0] = st_reg.llc_applied;
        stat_view[3] = port_reset_detect;
        stat_view[4] = test_mode;
        stat_view[5] = drive_connected;
        stat_view[6] = phy_ctl.transmit_only_active;
        stat_view[7] = phy_ctl.near_loopback_active;
    end

    // Port clears scrambler bit on scrambled responder transmit entry
    assign scr_auto_clear = responder_tx_entry &&
        (received_pattern_definition == stc_pkg::STC_PD_SCRAMBLED); // RL10

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.counter_clear_pulse = 1'b0;
        // Write address and data, either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = {s_axi_awaddr[11:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = (wr_ctrl ||
                st_reg.aw_addr == stc_pkg::STC_STAT_OFFSET) ?
                stc_pkg::STC_RESP_OKAY : stc_pkg::STC_RESP_SLVERR;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // Control fields, reserved bits dropped
        if (wr_ctrl) begin
            st_next.transmit_only_request =
                wr_merged[stc_pkg::STC_TXO_BIT]; // RL1
            st_next.counter_clear_pulse =
                wr_merged[stc_pkg::STC_TEST_COUNTER_CLEAR_BIT]; // RL2
            st_next.near_analog_loopback_request =
                wr_merged[stc_pkg::STC_LOOP_BIT]; // RL3
            st_next.link_layer_control =
                wr_merged[stc_pkg::STC_LLC_LSB +: 3];
            st_next.outside_frame_error_allow =
                wr_merged[stc_pkg::STC_ERR_BIT]; // RL11
            st_next.flip = wr_merged[stc_pkg::STC_FLIP_BIT];
            st_next.pattern_long = wr_merged[stc_pkg::STC_PV_BIT];
            st_next.pattern_sel = wr_merged[stc_pkg::STC_PAT_LSB +: 4];
        end
        // Hardware clear wins over a software write
        if (scr_auto_clear) begin
            st_next.link_layer_control[0] = 1'b0; // RL10
        end
        // Link settings move only under port reset in normal mode
        if (test_mode || port_reset_detect) begin
            st_next.llc_applied = st_next.link_layer_control; // RL6
        end
        // Reads
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            case (s_axi_araddr[11:2])
                stc_pkg::STC_CTRL_OFFSET[11:2]: begin
                    st_next.rdata = ctrl_view;
                    st_next.rresp = stc_pkg::STC_RESP_OKAY;
                end
                stc_pkg::STC_STAT_OFFSET[11:2]: begin
                    st_next.rdata = stat_view;
                    st_next.rresp = stc_pkg::STC_RESP_OKAY;
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = stc_pkg::STC_RESP_SLVERR;
                end
            endcase
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.link_layer_control <= stc_pkg::STC_LLC_RESET;
            st_reg.llc_applied <= stc_pkg::STC_LLC_RESET;
            st_reg.pattern_sel <= stc_pkg::STC_PAT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link layer enables, sense inverts in test mode
    always_comb begin
        llc_en.primitive_drop_en =
            st_reg.llc_applied[stc_pkg::STC_RPD_BIT - stc_pkg::STC_LLC_LSB]
            ^ test_mode; // RL7
        llc_en.descrambler_en =
            st_reg.llc_applied[stc_pkg::STC_DESC_BIT - stc_pkg::STC_LLC_LSB]
            ^ test_mode; // RL8
        llc_en.scrambler_en =
            st_reg.llc_applied[stc_pkg::STC_SCR_BIT - stc_pkg::STC_LLC_LSB]
            ^ test_mode; // RL9
    end

    // Physical layer test controls
    always_comb begin
        phy_ctl.transmit_only_active =
            st_reg.transmit_only_request && !drive_connected; // RL1
        phy_ctl.near_loopback_active =
            st_reg.near_analog_loopback_request; // RL3
        phy_ctl.test_activate_allow =
            !st_reg.near_analog_loopback_request; // RL4
        phy_ctl.pattern_sel = st_reg.pattern_sel;
        phy_ctl.pattern_valid =
            (st_reg.pattern_sel <= stc_pkg::STC_PAT_LFTP); // RL12
        phy_ctl.pattern_long = st_reg.pattern_long;
        phy_ctl.flip_disparity = st_reg.flip;
        phy_ctl.outside_frame_error_allow =
            st_reg.outside_frame_error_allow; // RL11
    end

    // One-cycle counter clear to the counter registers
    assign test_counter_clear = st_reg.counter_clear_pulse; // RL2

endmodule
`default_nettype wire

/* File: tb/stc_control_properties.sv */
// Port level checks for the self-test control block
`timescale 1ns/100ps
`default_nettype none
module stc_control_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Port side
    input wire logic port_reset_detect,
    input wire logic test_mode,
    input wire logic drive_connected,
    input wire logic responder_tx_entry,
    input wire logic [7:0] received_pattern_definition,
    input wire stc_pkg::stc_llc_en_t llc_en,
    input wire stc_pkg::stc_phy_ctl_t phy_ctl,
    input wire logic test_counter_clear
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    a_txo_gate: assert property (
        phy_ctl.transmit_only_active |-> !drive_connected)
        else $error("transmit-only active with drive attached");
    a_loop_block: assert property (
        phy_ctl.near_loopback_active |-> !phy_ctl.test_activate_allow)
        else $error("test-activate allowed during loopback");
    a_clear_pulse: assert property (
        test_counter_clear |=> !test_counter_clear)
        else $error("counter clear longer than one cycle");
    a_llc_frozen: assert property (
        !test_mode && !port_reset_detect && $past(!test_mode)
        && $past(!port_reset_detect) |-> $stable(llc_en))
        else $error("link enables moved while frozen");
    a_pat_valid: assert property (
        phy_ctl.pattern_valid == (phy_ctl.pattern_sel <= 4'h8))
        else $error("pattern valid flag wrong");
    a_write_resp: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_scr_entry: assert property (
        responder_tx_entry && test_mode && received_pattern_definition
        == stc_pkg::STC_PD_SCRAMBLED ##1 test_mode[*3]
        |-> llc_en.scrambler_en) else $error("scrambler not enabled");
endmodule
bind stc_control stc_control_props chk_u (.core_clk(core_clk),
    .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .port_reset_detect(port_reset_detect),
    .test_mode(test_mode), .drive_connected(drive_connected),
    .responder_tx_entry(responder_tx_entry), .llc_en(llc_en),
    .received_pattern_definition(received_pattern_definition),
    .phy_ctl(phy_ctl), .test_counter_clear(test_counter_clear));
`default_nettype wire

/* File: tb/stc_port_model.sv */
// Behavioural model of the port and attached drive status
`timescale 1ns/100ps
`default_nettype none
module stc_port_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Commands: reset detect, test mode, connected, entry, definition
    input wire logic [11:0] cmd,
    // Status to the block
    output logic port_reset_detect,
    output logic test_mode,
    output logic drive_connected,
    output logic responder_tx_entry,
    output logic [7:0] received_pattern_definition
);
    // Status registered; definition only meaningful with entry pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_reset_detect <= 1'b1;
            test_mode <= 1'b0;
            drive_connected <= 1'b0;
            responder_tx_entry <= 1'b0;
            received_pattern_definition <= 8'h00;
        end else begin
            port_reset_detect <= cmd[11];
            test_mode <= cmd[10];
            drive_connected <= cmd[9];
            responder_tx_entry <= cmd[8];
            received_pattern_definition <= cmd[8] ? cmd[7:0]
                : ~received_pattern_definition;
        end
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the self-test control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic core_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
    logic rvalid, clr, prd, tm, conn, ent;
    logic [11:0] awaddr = 0, araddr = 0, cmd = 12'h800;
    logic [31:0] wdata = 0, d, q, rdata;
    logic [1:0] r, bresp, rresp;
    logic [7:0] pd;
    stc_pkg::stc_llc_en_t llc_en;
    stc_pkg::stc_phy_ctl_t phy_ctl;
    int err_count = 0, n_checks = 0, cyc = 0, nclr = 0, eclr = 0;
    ////////////////////////////////////////////////////////////////////
    // Clock
    always #2 core_clk = ~core_clk;
    stc_control dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .port_reset_detect(prd),
        .test_mode(tm), .drive_connected(conn), .responder_tx_entry(ent),
        .received_pattern_definition(pd), .llc_en(llc_en),
        .phy_ctl(phy_ctl), .test_counter_clear(clr));
    stc_port_model port_u (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd),
        .port_reset_detect(prd), .test_mode(tm), .drive_connected(conn),
        .responder_tx_entry(ent), .received_pattern_definition(pd));
    // Timeout and clear pulse counting
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (clr === 1'b1) nclr <= nclr + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            summarize;
        end
    end
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] exp_rd(input logic [31:0] v);
        return v & 32'h0005_077f;
    endfunction
    function automatic logic [2:0] exp_llc(input logic [31:0] v,
                                           input logic t);
        return {v[8], v[9], v[10]} ^ {3{t}};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // One bus transfer, each channel released when taken
    task automatic axi(input bit wr, input logic [11:0] a,
        input logic [31:0] dv, output logic [31:0] qv, output logic [1:0] rv);
        logic av, wv, dn;
        dn = 0;
        @(posedge core_clk);
        if (wr) begin
            awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= dv; bready <= 1;
        end else begin
            arvalid <= 1; araddr <= a; rready <= 1;
        end
        while (!dn) begin
            // Sample handshakes at the rising edge that takes them
            @(posedge core_clk);
            av = wr ? awvalid && awready : arvalid && arready;
            wv = wvalid && wready;
            dn = wr ? bvalid : rvalid;
            qv = rdata;
            rv = wr ? bresp : rresp;
            if (wr && av) awvalid <= 0;
            if (!wr && av) arvalid <= 0;
            if (wr && wv) wvalid <= 0;
            if (dn) bready <= 0;
            if (dn) rready <= 0;
        end
    endtask
    task automatic summarize;
        $display("Checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(85));
        repeat (5) @(posedge core_clk);
        rst_n <= 1;
        axi(0, 12'h000, 0, q, r);
        chk("ctrl reset", 32'h0000_0700, q);
        for (int i = 0; i < 12; i++) begin
            d = i == 0 ? 32'hffff_ffff : (i == 1 ? 32'h0 : $urandom);
            cmd <= {2'($urandom | 2), !d[16] && 1'($urandom), 9'h0};
            eclr += int'(d[17]);
            axi(1, 12'h000, d, q, r);
            axi(0, 12'h000, 0, q, r);
            chk("ctrl", exp_rd(d), q);
            chk("txo", 32'(d[18] && !conn),
                32'(phy_ctl.transmit_only_active));
            chk("loop", 32'(d[16]), 32'(phy_ctl.near_loopback_active));
            chk("activate", 32'(!d[16]),
                32'(phy_ctl.test_activate_allow));
            chk("pattern", 32'(d[3:0]), 32'(phy_ctl.pattern_sel));
            chk("pat ok", 32'(d[3:0] <= 4'h8),
                32'(phy_ctl.pattern_valid));
            chk("err allow", 32'(d[6]),
                32'(phy_ctl.outside_frame_error_allow));
            chk("llc", 32'(exp_llc(d, tm)), 32'(llc_en));
        end
        chk("clear pulses", eclr, nclr);
        axi(1, 12'h000, 32'h0000_0700, q, r);
        cmd <= 12'h000;
        axi(1, 12'h000, 32'h0, q, r);
        repeat (4) @(posedge core_clk);
        chk("llc frozen", 32'h7, 32'(llc_en));
        cmd <= 12'h800;
        repeat (4) @(posedge core_clk);
        chk("llc applied", 32'h0, 32'(llc_en));
        cmd <= 12'hc00;
        axi(1, 12'h000, 32'h0000_0100, q, r);
        cmd <= 12'hd80;
        @(posedge core_clk);
        cmd <= 12'hc00;
        repeat (4) @(posedge core_clk);
        axi(0, 12'h000, 0, q, r);
        chk("scrambler bit", 32'h0, q);
        chk("scrambler en", 32'h1, 32'(llc_en.scrambler_en));
        axi(1, 12'h008, 32'hffff_ffff, q, r);
        chk("wr resp", 32'(stc_pkg::STC_RESP_SLVERR), 32'(r));
        axi(0, 12'h008, 0, q, r);
        chk("rd resp", 32'(stc_pkg::STC_RESP_SLVERR), 32'(r));
        chk("rd data", 32'h0, q);
        axi(1, 12'h004, 32'hffff_ffff, q, r);
        chk("ro resp", 32'(stc_pkg::STC_RESP_OKAY), 32'(r));
        axi(0, 12'h000, 0, q, r);
        chk("ctrl kept", 32'h0, q);
        summarize;
    end
endmodule
`default_nettype wire
